// ==== rtl/spo_pkg.sv ====
// Package with register map, field layouts, timing constants and carriers for the interrupt scheduler.
package spo_pkg;
    localparam int unsigned CLK_HZ         = 100_000_000;
    // Register word addresses in the setup area.
    localparam logic [7:0]  ADDR_TIME_BASE = 8'hc3;
    localparam logic [7:0]  ADDR_PWR_SETUP = 8'he1;
    localparam logic [7:0]  ADDR_INT4_IVL  = 8'h04;
    localparam logic [7:0]  ADDR_INT5_IVL  = 8'h05;
    localparam logic [7:0]  ADDR_STATUS    = 8'h10;
    // Field layouts and reset values.
    localparam int          TB_LSB         = 0;
    localparam int          TB_MSB         = 3;
    localparam logic [3:0]  TB_10MS        = 4'h0;
    localparam logic [3:0]  TB_1MS         = 4'h1;
    localparam logic [3:0]  TB_100US       = 4'h2;
    localparam int          PWR_EN_BIT     = 15;
    localparam int          DLY_LSB        = 0;
    localparam int          DLY_MSB        = 7;
    localparam logic [7:0]  DLY_MAX        = 8'h0a;
    localparam logic [15:0] SETUP_RST      = 16'h0000;
    // Times in microseconds and derived cycle counts.
    localparam int unsigned T_10MS_US      = 10000;
    localparam int unsigned T_1MS_US       = 1000;
    localparam int unsigned T_100US_US     = 100;
    localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
    localparam int unsigned CYC_10MS       = T_10MS_US * CYC_PER_US;
    localparam int unsigned CYC_1MS        = T_1MS_US * CYC_PER_US;
    localparam int unsigned CYC_100US      = T_100US_US * CYC_PER_US;
    localparam int unsigned DET_TIME_US    = 10000;
    // Task numbers.
    localparam logic [7:0]  TASK_PWR       = 8'h01;
    localparam logic [7:0]  TASK_SCHED0    = 8'h02;
    localparam logic [7:0]  TASK_SCHED1    = 8'h03;

    typedef enum logic [3:0] {
        SPO_IDLE   = 4'h1,
        SPO_DETECT = 4'h2,
        SPO_RUN    = 4'h4,
        SPO_HALT   = 4'h8
    } spo_pwr_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } spo_reg_req_t;
endpackage : spo_pkg

// ==== rtl/spo_tick_cnt.sv ====
// Periodic interval counter raising one task request per programmed interval.
module spo_tick_cnt (
    input  wire logic        ref_clk,  // System clock.
    input  wire logic        rst_b,    // Synchronous reset, active low.
    input  wire logic        tick,     // Time-base tick pulse.
    input  wire logic        load,     // Interval write pulse.
    input  wire logic [15:0] ivl,      // Interval count, zero disables.
    output logic             fire_q    // One-cycle request pulse.
);
    logic [15:0] ivl_q, ivl_d, cnt_q, cnt_d;
    logic        fire_d;

    // Counts ticks and reloads on each expiry.
    always_comb begin
        ivl_d  = ivl_q;
        cnt_d  = cnt_q;
        fire_d = 1'b0;
        if (load) begin
            ivl_d = ivl;
            cnt_d = 16'h0000;
        end else if (ivl_q != 16'h0000 && tick) begin
            if (cnt_q + 16'h0001 >= ivl_q) begin
                cnt_d  = 16'h0000;
                fire_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    // Registers counter state; disabled after reset.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ivl_q  <= 16'h0000;
            cnt_q  <= 16'h0000;
            fire_q <= 1'b0;
        end else begin
            ivl_q  <= ivl_d;
            cnt_q  <= cnt_d;
            fire_q <= fire_d;
        end
    end
endmodule : spo_tick_cnt

// ==== rtl/spo_sched_pwr.sv ====
// Scheduled and power-off interrupt controller.
module spo_sched_pwr #(
    parameter int unsigned DET_CYC = spo_pkg::DET_TIME_US * spo_pkg::CYC_PER_US,  // Fixed detection time.
    parameter int unsigned MS_CYC  = spo_pkg::CYC_1MS,                            // Cycles per millisecond.
    parameter int unsigned BUD_CYC = spo_pkg::CYC_10MS                            // Power-off budget.
) (
    input  wire logic                 ref_clk,      // System clock, 100 MHz.
    input  wire logic                 rst_b,        // Synchronous reset, active low.
    input  wire spo_pkg::spo_reg_req_t reg_req,     // Register access from the CPU.
    output logic [15:0]               reg_rdata_q,  // Register read data.
    input  wire logic                 power_fail,   // Power-loss detect pin.
    input  wire logic                 online_edit,  // Online edit in progress.
    input  wire logic                 task_busy,    // An interrupt task is running.
    input  wire logic                 task_done,    // Running periodic task finished.
    output logic                      task_req_q,   // Task start pulse.
    output logic [7:0]                task_num_q,   // Task number to start.
    output logic                      task_abort_q, // Kill running interrupt task.
    output logic                      exec_stop_q   // Stop execution of power-off task.
);
    localparam int unsigned CW = 32;

    // Setup words, prescaler and power-off counter.
    logic [15:0]             tb_q;
    logic [15:0]             tb_d;
    logic [15:0]             pwr_q;
    logic [15:0]             pwr_d;
    logic [CW-1:0]           pre_q;
    logic [CW-1:0]           pre_d;
    logic [CW-1:0]           cnt_q;
    logic [CW-1:0]           cnt_d;
    logic [CW-1:0]           lim;
    logic                    tick;
    logic [7:0]              dly;
    // Pending records, synchroniser and dispatch state.
    logic [1:0]              pend_q;
    logic [1:0]              pend_d;
    logic                    fire4;
    logic                    fire5;
    logic                    pf_s1_q;
    logic                    pf_s2_q;
    spo_pkg::spo_pwr_state_t st_q;
    spo_pkg::spo_pwr_state_t st_d;
    logic                    req_d;
    logic                    abort_d;
    logic                    stop_d;
    logic [7:0]              num_d;
    logic [15:0]             rd_d;

    // Two-flop synchroniser for the power-fail pin.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pf_s1_q <= 1'b0;
            pf_s2_q <= 1'b0;
        end else begin
            pf_s1_q <= power_fail;
            pf_s2_q <= pf_s1_q;
        end
    end

    // Setup register writes; delay code above ten is clamped.
    always_comb begin
        tb_d  = tb_q;
        pwr_d = pwr_q;
        if (reg_req.wr && reg_req.addr == spo_pkg::ADDR_TIME_BASE) begin
            tb_d = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == spo_pkg::ADDR_PWR_SETUP) begin
            pwr_d = reg_req.wdata;
            if (reg_req.wdata[spo_pkg::DLY_MSB:spo_pkg::DLY_LSB] > spo_pkg::DLY_MAX) begin
                pwr_d[spo_pkg::DLY_MSB:spo_pkg::DLY_LSB] = spo_pkg::DLY_MAX;
            end
        end
    end

    // Time-base prescaler selected by the setup code.
    // A code change acts at once; a prescaler already past the new limit wraps on the next edge.
    always_comb begin
        case (tb_q[spo_pkg::TB_MSB:spo_pkg::TB_LSB])
            spo_pkg::TB_1MS:   lim = CW'(spo_pkg::CYC_1MS);
            spo_pkg::TB_100US: lim = CW'(spo_pkg::CYC_100US);
            default:           lim = CW'(spo_pkg::CYC_10MS);
        endcase
        tick  = (pre_q + 32'h1 >= lim);
        pre_d = tick ? 32'h0 : pre_q + 32'h1;
    end

    // Interval counters: interrupt 4 and 5.
    spo_tick_cnt u_int4 (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tick    (tick),
        .load    (reg_req.wr && reg_req.addr == spo_pkg::ADDR_INT4_IVL),
        .ivl     (reg_req.wdata),
        .fire_q  (fire4)
    );
    spo_tick_cnt u_int5 (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tick    (tick),
        .load    (reg_req.wr && reg_req.addr == spo_pkg::ADDR_INT5_IVL),
        .ivl     (reg_req.wdata),
        .fire_q  (fire5)
    );

    assign dly = pwr_q[spo_pkg::DLY_MSB:spo_pkg::DLY_LSB];

    // Power-off sequence and task dispatch.
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        pend_d  = pend_q | {fire5, fire4};  // One pending record per periodic task.
        req_d   = 1'b0;
        num_d   = task_num_q;
        abort_d = 1'b0;
        stop_d  = exec_stop_q;
        case (st_q)
            spo_pkg::SPO_IDLE: begin
                // Power-off detection outranks any pending periodic dispatch.
                if (pf_s2_q && pwr_q[spo_pkg::PWR_EN_BIT] && !online_edit) begin
                    st_d  = spo_pkg::SPO_DETECT;
                    cnt_d = 32'h0;
                end else if (!task_busy && pend_q[0]) begin
                    req_d     = 1'b1;
                    num_d     = spo_pkg::TASK_SCHED0;
                    pend_d[0] = fire4;
                end else if (!task_busy && pend_q[1]) begin
                    req_d     = 1'b1;
                    num_d     = spo_pkg::TASK_SCHED1;
                    pend_d[1] = fire5;
                end
            end
            spo_pkg::SPO_DETECT: begin
                // Periodic dispatch waits here; pending records keep collecting until the power-off start clears them.
                cnt_d = cnt_q + 32'h1;
                if (online_edit) begin
                    st_d = spo_pkg::SPO_IDLE;
                end else if (cnt_q + 32'h1 >= CW'(DET_CYC) + CW'(dly) * CW'(MS_CYC)) begin
                    st_d    = spo_pkg::SPO_RUN;
                    cnt_d   = 32'h0;
                    req_d   = 1'b1;
                    num_d   = spo_pkg::TASK_PWR;
                    abort_d = task_busy;
                    pend_d  = 2'b00;
                end
            end
            spo_pkg::SPO_RUN: begin
                // A full delay code leaves no budget, so the stop follows the start by one cycle.
                cnt_d  = cnt_q + 32'h1;
                pend_d = 2'b00;
                if (cnt_q + 32'h1 >= CW'(BUD_CYC) - CW'(dly) * CW'(MS_CYC)) begin
                    st_d   = spo_pkg::SPO_HALT;
                    stop_d = 1'b1;
                end
            end
            spo_pkg::SPO_HALT: begin
                stop_d = 1'b1;
                pend_d = 2'b00;
            end
            default: st_d = spo_pkg::SPO_IDLE;
        endcase
    end

    // Register read mux.
    // Data is zero outside a read cycle, so a stale word never lingers on the bus.
    always_comb begin
        case (reg_req.addr)
            spo_pkg::ADDR_TIME_BASE: rd_d = tb_q;
            spo_pkg::ADDR_PWR_SETUP: rd_d = pwr_q;
            spo_pkg::ADDR_STATUS:    rd_d = {9'h000, exec_stop_q, st_q, pend_q};
            default:                 rd_d = 16'h0000;
        endcase
        if (!reg_req.rd) rd_d = 16'h0000;
    end

    // State registers; all sources disabled at reset.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tb_q         <= spo_pkg::SETUP_RST;
            pwr_q        <= spo_pkg::SETUP_RST;
            pre_q        <= 32'h0;
            cnt_q        <= 32'h0;
            pend_q       <= 2'b00;
            st_q         <= spo_pkg::SPO_IDLE;
            task_req_q   <= 1'b0;
            task_num_q   <= 8'h00;
            task_abort_q <= 1'b0;
            exec_stop_q  <= 1'b0;
            reg_rdata_q  <= 16'h0000;
        end else begin
            tb_q         <= tb_d;
            pwr_q        <= pwr_d;
            pre_q        <= pre_d;
            cnt_q        <= cnt_d;
            pend_q       <= pend_d;
            st_q         <= st_d;
            task_req_q   <= req_d;
            task_num_q   <= num_d;
            task_abort_q <= abort_d;
            exec_stop_q  <= stop_d;
            reg_rdata_q  <= rd_d;
        end
    end
endmodule : spo_sched_pwr

// ==== tb/spo_sched_pwr_assertions.sv ====
// Checker module with port-level properties for the interrupt scheduler, and its bind.
module spo_sched_pwr_checker (
    input wire logic                  ref_clk,      // System clock.
    input wire logic                  rst_b,        // Synchronous reset, active low.
    input wire spo_pkg::spo_reg_req_t reg_req,      // Register access.
    input wire logic [15:0]           reg_rdata_q,  // Read data.
    input wire logic                  power_fail,   // Power-loss pin.
    input wire logic                  task_req_q,   // Task start pulse.
    input wire logic [7:0]            task_num_q,   // Task number.
    input wire logic                  task_abort_q, // Abort pulse.
    input wire logic                  exec_stop_q   // Stop level.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic seen_pwr_q;
    logic seen_pwr_d;
    logic pwr_req;
    // Remembers that a power-off task was started since reset.
    assign pwr_req = task_req_q && (task_num_q == 8'h01);
    always_comb seen_pwr_d = seen_pwr_q | pwr_req;
    always_ff @(posedge ref_clk) seen_pwr_q <= rst_b ? seen_pwr_d : 1'b0;
    logic full_dly_q;
    // Remembers that the delay code leaves no power-off budget at all.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) full_dly_q <= 1'b0;
        else if (reg_req.wr && reg_req.addr == 8'he1) full_dly_q <= (reg_req.wdata[7:0] >= 8'h0a);
    end

    a_rdata_idle_zero: assert property (!reg_req.rd |=> reg_rdata_q == 16'h0000)
        else $error("read data not zero without a read");
    a_delay_code_clamp: assert property (reg_req.rd && reg_req.addr == 8'he1 |=> reg_rdata_q[7:0] <= 8'h0a)
        else $error("delay code above limit");
    a_unmapped_reads_zero: assert property (reg_req.rd && !(reg_req.addr inside {8'hc3, 8'he1, 8'h10})
        |=> reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
    a_task_num_legal: assert property (task_req_q |-> task_num_q inside {8'h01, 8'h02, 8'h03})
        else $error("illegal task number");
    a_abort_with_pwr: assert property (task_abort_q |-> pwr_req)
        else $error("abort without power-off start");
    a_pwr_needs_fail: assert property (pwr_req |-> $past(power_fail, 3) && power_fail)
        else $error("power-off start without power loss");
    a_stop_after_start: assert property (exec_stop_q |-> seen_pwr_q)
        else $error("stop without power-off task");
    a_stop_not_at_start: assert property (pwr_req && !full_dly_q |=> !exec_stop_q)
        else $error("stop at power-off start");
    a_stop_holds: assert property (exec_stop_q |=> exec_stop_q)
        else $error("stop released");
    c_sched: cover property (task_req_q && task_num_q == 8'h02);
    c_abort: cover property (task_abort_q);
    c_stop: cover property ($rose(exec_stop_q));
endmodule : spo_sched_pwr_checker

bind spo_sched_pwr spo_sched_pwr_checker u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .power_fail(power_fail), .task_req_q(task_req_q), .task_num_q(task_num_q),
    .task_abort_q(task_abort_q), .exec_stop_q(exec_stop_q));

// ==== tb/spo_sched_pwr_tb_top.sv ====
// Self-checking testbench for the scheduled and power-off interrupt controller.
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module spo_sched_pwr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DET = 50;
    localparam int MS  = 10;
    localparam int BUD = 100;
    logic                  ref_clk = 1'b0;
    logic                  rst_b = 1'b0;
    spo_pkg::spo_reg_req_t req = '0;
    logic [15:0]           rdata;
    logic                  power_fail = 1'b0;
    logic                  online_edit = 1'b0;
    logic                  task_busy = 1'b0;
    logic                  task_req, abort, stop;
    logic [7:0]            num;
    int                    fails = 0;
    int                    checks_done = 0;
    int                    n;
    int                    m;
    int                    m_d [2] = '{0, 4};

    spo_sched_pwr #(.DET_CYC(DET), .MS_CYC(MS), .BUD_CYC(BUD)) uut (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(req), .reg_rdata_q(rdata),
        .power_fail(power_fail), .online_edit(online_edit), .task_busy(task_busy),
        .task_done(1'b0), .task_req_q(task_req), .task_num_q(num),
        .task_abort_q(abort), .exec_stop_q(stop));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        power_fail <= 1'b0;
        online_edit <= 1'b0;
        task_busy <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= spo_pkg::spo_reg_req_t'({1'b1, 1'b0, a, d});
        @(posedge ref_clk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        req <= spo_pkg::spo_reg_req_t'({1'b0, 1'b1, a, 16'h0000});
        @(posedge ref_clk);
        req <= '0;
        #1;
        `CHK(rdata, exp)
    endtask : rd
    task automatic wait_req(input int lim, output int cnt);
        cnt = 0;
        while (task_req !== 1'b1 && cnt < lim) begin
            step();
            cnt++;
        end
    endtask : wait_req
    task automatic final_report();
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Cuts a hang short after about 60,000 cycles, twice the expected run.
    initial begin
        #600000;
        fails++;
        final_report();
    end

    // Main test sequence.
    initial begin
        do_reset();
        rd(8'h10, 16'h0004);
        rd(8'hc3, 16'h0000);
        rd(8'he1, 16'h0000);
        rd(8'h77, 16'h0000);
        for (int c = 0; c < 3; c++) begin
            wr(8'hc3, 16'(c));
            rd(8'hc3, 16'(c));
        end
        wr(8'he1, 16'h800c);
        rd(8'he1, 16'h800a);
        wr(8'he1, 16'h0000);
        power_fail <= 1'b1;
        wait_req(300, n);
        `CHK(task_req, 1'b0)
        do_reset();
        wr(8'hc3, 16'h0002);
        wr(8'h04, 16'h0001);
        wait_req(12000, n);
        `CHK(num, 8'h02)
        step();
        wait_req(12000, n);
        `CHK(n >= 9997 && n <= 10001, 1'b1)
        @(posedge ref_clk);
        task_busy <= 1'b1;
        wr(8'h05, 16'h0001);
        repeat (10100) @(posedge ref_clk);
        wr(8'h04, 16'h0000);
        wr(8'h05, 16'h0000);
        task_busy <= 1'b0;
        wait_req(50, n);
        `CHK(num, 8'h02)
        step();
        wait_req(50, n);
        `CHK(num, 8'h03)
        do_reset();
        wr(8'he1, 16'h8000);
        online_edit <= 1'b1;
        power_fail <= 1'b1;
        wait_req(300, n);
        `CHK(task_req, 1'b0)
        foreach (m_d[i]) begin
            do_reset();
            wr(8'he1, 16'h8000 | 16'(m_d[i]));
            task_busy <= 1'b1;
            power_fail <= 1'b1;
            @(posedge ref_clk);
            #1;
            wait_req(400, n);
            `CHK(n >= DET + m_d[i] * MS && n <= DET + m_d[i] * MS + 5, 1'b1)
            `CHK(num, 8'h01)
            `CHK(abort, 1'b1)
            m = 0;
            while (stop !== 1'b1 && m < 300) begin
                step();
                m++;
            end
            `CHK(m >= BUD - m_d[i] * MS - 2 && m <= BUD - m_d[i] * MS + 2, 1'b1)
            rd(8'h10, 16'h0060);
        end
        final_report();
    end
endmodule : spo_sched_pwr_tb_top
